/* core/icr_pkg.sv */
// shared constants for the interpolator configuration register bank
package icr_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 16;

    // register offsets
    localparam logic [3:0] ADR_FORMAT    = 4'h0;
    localparam logic [3:0] ADR_HYST      = 4'h1;
    localparam logic [3:0] ADR_INCR      = 4'h2;
    localparam logic [3:0] ADR_LINK      = 4'h3;
    localparam logic [3:0] ADR_FLIM_LO   = 4'h4;
    localparam logic [3:0] ADR_FLIM_HI   = 4'h5;
    localparam logic [3:0] ADR_TIMEOUT   = 4'h6;
    localparam logic [3:0] ADR_TO_EXT    = 4'h7;
    localparam logic [3:0] ADR_GAIN      = 4'h8;
    localparam logic [3:0] ADR_COS_TRIM  = 4'h9;
    localparam logic [3:0] ADR_PHASE     = 4'hB;
    localparam logic [3:0] ADR_AMPLITUDE_THRESHOLD_CODE      = 4'hC;
    localparam logic [3:0] ADR_UNUSED_A  = 4'hD;
    localparam logic [3:0] ADR_UNUSED_B  = 4'hE;
    localparam logic [3:0] ADR_CHECKSUM  = 4'hF;

    // field positions
    localparam int RES_MSB      = 4;
    localparam int PROT_BIT     = 3;
    localparam int STATUS_W     = 3;
    localparam int GAIN_MSB     = 7;
    localparam int GAIN_LSB     = 4;
    localparam int FLIM_HI_MSB  = 6;
    localparam int AMP_SEL_BIT  = 2;
    localparam int AMP_CODE_MSB = 1;

    // amplitude thresholds in mV, indexed by the 2-bit threshold code except the single upper limit
    localparam int MV_W = 13;
    localparam logic [3:0][12:0] MIN_TH_MV = {13'h0E10, 13'h0D48, 13'h0C80, 13'h0BB8};
    localparam logic [3:0][12:0] LOW_TH_MV = {13'h09C4, 13'h07D0, 13'h05DC, 13'h03E8};
    localparam logic [12:0]      UPPER_TH_MV = 13'h1194;

    // fault indication timing
    localparam int CLK_KHZ        = 40000;
    localparam int FAULT_HOLD_MS  = 10;
    localparam int FAULT_HOLD_CYC = FAULT_HOLD_MS * CLK_KHZ;

    typedef enum logic {FLT_IDLE, FLT_SHOW} icr_fault_t;
endpackage

/* core/icr_reg_mem.sv */
// sixteen-byte configuration store with registered read port
module icr_reg_mem (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // write port
    input  wire logic                   wrEn,
    input  wire logic [3:0]             wrAddr,
    input  wire logic [7:0]             wrData,
    // read port
    input  wire logic                   rdEn,
    input  wire logic [3:0]             rdAddr,
    input  wire logic [2:0]             statusBits,
    output logic      [7:0]             rdData,
    // all cells, flat, byte n at bits 8n+7:8n
    output logic      [127:0]           cells
);
    logic [7:0] mem [icr_pkg::NUM_REGS];

    // storage has no reset: contents are unknown until loaded
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // flat view of the cells for the field decoders
    for (genvar i = 0; i < icr_pkg::NUM_REGS; i++) begin : g_flat
        assign cells[i*8 +: 8] = mem[i];
    end

    // live status bits replace the low bits of the link byte on read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            if (rdAddr == icr_pkg::ADR_LINK) begin
                rdData <= {mem[rdAddr][7:icr_pkg::STATUS_W], statusBits};
            end else begin
                rdData <= mem[rdAddr];
            end
        end
    end
endmodule

/* core/icr_config_regs.sv */
// configuration register bank with amplitude monitor and fault pin driver
// How it works
// - with no start-up load the stored bytes are undefined; no reset value assumed
// - unprotected, every register accepts host reads and writes
// - byte at 0x0F holds the loaded checksum covering bytes 0x00 to 0x0E
// - check select 0: amplitude compared to one minimum, code steps it upward
// - check select 1: squared sum checked against one upper limit for codes 4..7
// - check select 1: lower limit rises with code from 4; outside window is error
// - amplitude and frequency fault flags read zero when the error is present
// - any fault pulls the fault pin low at least 10 ms while the link is idle
module icr_config_regs #(
    parameter int unsigned HOLD_CYCLES = icr_pkg::FAULT_HOLD_CYC
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // register access, host or start-up load
    input  wire logic [3:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    input  wire logic                   regWrEn,
    input  wire logic                   eepromLoad,
    input  wire logic                   regRdEn,
    output logic      [7:0]             regRdData,
    output logic                        regRdValid,
    // converter measurements
    input  wire logic [12:0]            amplitudeMv,
    input  wire logic [12:0]            squareSumMv,
    input  wire logic                   freqFault,
    // serial link state
    input  wire logic                   serialClockIn,
    input  wire logic                   accessBusy,
    // open-drain fault pin
    input  wire logic                   faultPinIn,
    output logic                        faultPinOut,
    output logic                        faultPinOe,
    output logic                        faultPinLevel,
    // decoded configuration and active-low fault flags
    output logic      [4:0]             resolutionSelect,
    output logic      [3:0]             gainCode,
    output logic      [14:0]            converterFrequencyLimit,
    output logic      [7:0]             storedChecksumByte,
    output logic                        writeProtectLevel,
    output logic                        amplitudeCheckSelect,
    output logic      [1:0]             amplitudeThresholdCode,
    output logic                        amplitudeFaultFlagN,
    output logic                        frequencyFaultFlagN
);
    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

    logic [127:0]     cells;
    logic [7:0]       fmtByte;
    logic [7:0]       linkByte;
    logic [7:0]       gainByte;
    logic [7:0]       flimLoByte;
    logic [7:0]       flimHiByte;
    logic [7:0]       amplByte;
    logic             wrAllowed;
    logic             ampErr;
    logic             ampFlagN_q;
    logic             freqFlagN_q;
    logic             sclkMeta_q;
    logic             sclkSync_q;
    logic             pinMeta_q;
    logic             pinSync_q;
    logic             linkIdle;
    logic             anyFault;
    icr_pkg::icr_fault_t faultState_q;
    logic [CNT_W-1:0] holdCnt_q;

    // byte n of the flat store
    function automatic logic [7:0] cellByte(input logic [127:0] c, input logic [3:0] a);
        return c[a*8 +: 8];
    endfunction

    // protection blocks host writes only; the start-up load always lands
    assign wrAllowed = regWrEn && (eepromLoad || !writeProtectLevel);

    icr_reg_mem u_mem (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .wrEn       (wrAllowed),
        .wrAddr     (regAddr),
        .wrData     (regWrData),
        .rdEn       (regRdEn),
        .rdAddr     (regAddr),
        .statusBits ({1'b0, ampFlagN_q, freqFlagN_q}),
        .rdData     (regRdData),
        .cells      (cells)
    );

    // read data valid one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
        end
    end

    // bytes that carry decoded fields; a call result cannot be part-selected
    assign fmtByte    = cellByte(cells, icr_pkg::ADR_FORMAT);
    assign linkByte   = cellByte(cells, icr_pkg::ADR_LINK);
    assign gainByte   = cellByte(cells, icr_pkg::ADR_GAIN);
    assign flimLoByte = cellByte(cells, icr_pkg::ADR_FLIM_LO);
    assign flimHiByte = cellByte(cells, icr_pkg::ADR_FLIM_HI);
    assign amplByte   = cellByte(cells, icr_pkg::ADR_AMPLITUDE_THRESHOLD_CODE);

    // field decode straight from the store, unknown until loaded
    assign resolutionSelect = fmtByte[icr_pkg::RES_MSB:0];
    assign writeProtectLevel = linkByte[icr_pkg::PROT_BIT];
    assign gainCode = gainByte[icr_pkg::GAIN_MSB:icr_pkg::GAIN_LSB];
    assign converterFrequencyLimit = {flimHiByte[icr_pkg::FLIM_HI_MSB:0], flimLoByte};
    assign storedChecksumByte = cellByte(cells, icr_pkg::ADR_CHECKSUM);
    assign amplitudeCheckSelect = amplByte[icr_pkg::AMP_SEL_BIT];
    assign amplitudeThresholdCode = amplByte[icr_pkg::AMP_CODE_MSB:0];

    // amplitude check: single minimum or squared-sum window
    always_comb begin
        if (amplitudeCheckSelect) begin
            ampErr = (squareSumMv > icr_pkg::UPPER_TH_MV)
                  || (squareSumMv < icr_pkg::LOW_TH_MV[amplitudeThresholdCode]);
        end else begin
            ampErr = amplitudeMv < icr_pkg::MIN_TH_MV[amplitudeThresholdCode];
        end
    end

    // active-low flags, refreshed every cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ampFlagN_q  <= 1'b1;
            freqFlagN_q <= 1'b1;
        end else begin
            ampFlagN_q  <= !ampErr;
            freqFlagN_q <= !freqFault;
        end
    end
    assign amplitudeFaultFlagN = ampFlagN_q;
    assign frequencyFaultFlagN = freqFlagN_q;

    // pins come from outside, so two flops before use
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclkMeta_q <= 1'b1;
            sclkSync_q <= 1'b1;
            pinMeta_q  <= 1'b1;
            pinSync_q  <= 1'b1;
        end else begin
            sclkMeta_q <= serialClockIn;
            sclkSync_q <= sclkMeta_q;
            pinMeta_q  <= faultPinIn;
            pinSync_q  <= pinMeta_q;
        end
    end
    assign faultPinLevel = pinSync_q;

    // indication only while the link clock rests high and no access runs
    assign linkIdle = sclkSync_q && !accessBusy;
    assign anyFault = !ampFlagN_q || !freqFlagN_q;

    // hold timer: the low phase never ends before the count runs out
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            faultState_q <= icr_pkg::FLT_IDLE;
            holdCnt_q    <= '0;
        end else begin
            case (faultState_q)
                icr_pkg::FLT_IDLE: begin
                    if (anyFault && linkIdle) begin
                        faultState_q <= icr_pkg::FLT_SHOW;
                        holdCnt_q    <= CNT_W'(HOLD_CYCLES - 1);
                    end
                end
                icr_pkg::FLT_SHOW: begin
                    if (holdCnt_q != '0) begin
                        holdCnt_q <= holdCnt_q - 1'b1;
                    end else if (!anyFault) begin
                        faultState_q <= icr_pkg::FLT_IDLE;
                    end
                end
                default: begin
                    faultState_q <= icr_pkg::FLT_IDLE;
                end
            endcase
        end
    end

    // open drain: only ever pulls low, released during link traffic
    assign faultPinOut = 1'b0;
    assign faultPinOe  = (faultState_q == icr_pkg::FLT_SHOW) && linkIdle;

    property p_prot_block;
        @(posedge sys_clk) disable iff (rst)
        (regWrEn && !eepromLoad && writeProtectLevel) |=> $stable(cells);
    endproperty
    a_prot_block: assert property (p_prot_block) else $error("protected write changed a byte");

    property p_write_lands;
        @(posedge sys_clk) disable iff (rst)
        (regWrEn && (eepromLoad || !writeProtectLevel))
            |=> cellByte(cells, $past(regAddr)) == $past(regWrData);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("allowed write not stored");

    property p_checksum;
        @(posedge sys_clk) disable iff (rst)
        (wrAllowed && regAddr == icr_pkg::ADR_CHECKSUM)
            |=> storedChecksumByte == $past(regWrData);
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum byte not at top offset");

    property p_min_mode;
        @(posedge sys_clk) disable iff (rst)
        (!amplitudeCheckSelect && amplitudeMv < icr_pkg::MIN_TH_MV[amplitudeThresholdCode])
            |=> !amplitudeFaultFlagN;
    endproperty
    a_min_mode: assert property (p_min_mode) else $error("low amplitude not flagged");

    property p_upper;
        @(posedge sys_clk) disable iff (rst)
        (amplitudeCheckSelect && squareSumMv > icr_pkg::UPPER_TH_MV) |=> !amplitudeFaultFlagN;
    endproperty
    a_upper: assert property (p_upper) else $error("squared sum above limit not flagged");

    property p_window_ok;
        @(posedge sys_clk) disable iff (rst)
        (amplitudeCheckSelect && squareSumMv <= icr_pkg::UPPER_TH_MV
            && squareSumMv >= icr_pkg::LOW_TH_MV[amplitudeThresholdCode]) |=> amplitudeFaultFlagN;
    endproperty
    a_window_ok: assert property (p_window_ok) else $error("in-window sum flagged");

    property p_freq_flag;
        @(posedge sys_clk) disable iff (rst)
        freqFault |=> !frequencyFaultFlagN;
    endproperty
    a_freq_flag: assert property (p_freq_flag) else $error("frequency fault flag not low");

    property p_hold_start;
        @(posedge sys_clk) disable iff (rst)
        (faultState_q == icr_pkg::FLT_IDLE && anyFault && linkIdle)
            |=> faultState_q == icr_pkg::FLT_SHOW && holdCnt_q == CNT_W'(HOLD_CYCLES - 1);
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("fault indication did not start");

    property p_no_early_release;
        @(posedge sys_clk) disable iff (rst)
        (faultState_q == icr_pkg::FLT_SHOW && holdCnt_q != '0) |=> faultState_q == icr_pkg::FLT_SHOW;
    endproperty
    a_no_early_release: assert property (p_no_early_release) else $error("fault ended early");
endmodule

/* sim/icr_eeprom_model.sv */
// start-up configuration memory model that loads the register bank byte by byte
module icr_eeprom_model #(
    parameter logic [127:0] IMG = '0
) (
    // clock
    sys_clk,
    // load request and progress
    startLoad,
    ldBusy,
    // register write side
    ldAddr,
    ldData,
    ldWr
);
    timeunit 1ns;
    timeprecision 100ps;
    input  wire logic       sys_clk;
    input  wire logic       startLoad;
    output logic            ldBusy = 1'b0;
    output logic [3:0]      ldAddr = 4'h0;
    output logic [7:0]      ldData = 8'h00;
    output logic            ldWr   = 1'b0;

    // one byte per cycle; the image keeps reserved bits at zero and a gain code for the sensor
    always @(posedge startLoad) begin
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            #2;
            ldBusy = 1'b1;
            ldWr   = 1'b1;
            ldAddr = 4'(i);
            ldData = IMG[8*i +: 8];
        end
        @(posedge sys_clk);
        #2;
        ldWr   = 1'b0;
        ldBusy = 1'b0;
        ldData = ~ldData; // released data no longer shows the last byte
    end
endmodule

/* sim/interpolator_config_registers_tb.sv */
// self-checking bench for the configuration register bank
module interpolator_config_registers_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [7:0] cfg; logic [12:0] amp; logic [12:0] sq; logic flagN;} icr_row_t;
    localparam int HOLD = 20;
    localparam logic [127:0] IMG = 128'h3C00_0005_C681_8061_4040_4302_40A4_5A13;
    localparam logic [3:0][12:0] MN = icr_pkg::MIN_TH_MV;
    localparam logic [3:0][12:0] LW = icr_pkg::LOW_TH_MV;
    localparam logic [12:0]      UP = icr_pkg::UPPER_TH_MV;
    localparam logic [12:0]      D  = 13'h0064;

    logic        sys_clk = 1'b0, rst = 1'b1, hWr = 1'b0, hRd = 1'b0, startLoad = 1'b0;
    logic        freqFault = 1'b0, serialClockIn = 1'b1, accessBusy = 1'b1;
    logic [3:0]  hAddr = 4'h0, ldAddr;
    logic [7:0]  hData = 8'h00, ldData, regRdData, storedChecksumByte;
    logic [12:0] amplitudeMv = 13'h0FA0, squareSumMv = 13'h0BB8;
    logic        ldWr, ldBusy, regRdValid, faultPinOut, faultPinOe, faultPinLevel;
    logic        writeProtectLevel, amplitudeCheckSelect, amplitudeFaultFlagN, frequencyFaultFlagN;
    logic [4:0]  resolutionSelect;
    logic [3:0]  gainCode;
    logic [14:0] converterFrequencyLimit;
    logic [1:0]  amplitudeThresholdCode;
    int          n_mismatch = 0, total_checks = 0, n;
    icr_row_t    rows [13];

    always #12.5 sys_clk = ~sys_clk;

    icr_eeprom_model #(.IMG(IMG)) u_icr_eeprom_model (.sys_clk(sys_clk), .startLoad(startLoad),
        .ldBusy(ldBusy), .ldAddr(ldAddr), .ldData(ldData), .ldWr(ldWr));

    // start-up load owns the write port while it runs; pull-up on the fault wire
    icr_config_regs #(.HOLD_CYCLES(HOLD)) u_icr_config_regs (.sys_clk(sys_clk), .rst(rst),
        .regAddr(ldBusy ? ldAddr : hAddr), .regWrData(ldBusy ? ldData : hData),
        .regWrEn(ldBusy ? ldWr : hWr), .eepromLoad(ldBusy), .regRdEn(hRd),
        .regRdData(regRdData), .regRdValid(regRdValid), .amplitudeMv(amplitudeMv),
        .squareSumMv(squareSumMv), .freqFault(freqFault), .serialClockIn(serialClockIn),
        .accessBusy(accessBusy), .faultPinIn(faultPinOe ? 1'b0 : 1'b1),
        .faultPinOut(faultPinOut), .faultPinOe(faultPinOe), .faultPinLevel(faultPinLevel),
        .resolutionSelect(resolutionSelect), .gainCode(gainCode),
        .converterFrequencyLimit(converterFrequencyLimit),
        .storedChecksumByte(storedChecksumByte), .writeProtectLevel(writeProtectLevel),
        .amplitudeCheckSelect(amplitudeCheckSelect),
        .amplitudeThresholdCode(amplitudeThresholdCode),
        .amplitudeFaultFlagN(amplitudeFaultFlagN), .frequencyFaultFlagN(frequencyFaultFlagN));

    task automatic chk(string what, logic [14:0] exp, logic [14:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // every task starts and ends just after a rising edge
    task automatic tick(int c);
        repeat (c) @(posedge sys_clk);
        #2;
    endtask

    task automatic wr(logic [3:0] a, logic [7:0] d);
        hAddr = a;
        hData = d;
        hWr = 1'b1;
        tick(1);
        hWr = 1'b0;
        hData = ~d;
        tick(1);
    endtask

    task automatic rd(logic [3:0] a, logic [7:0] exp);
        hAddr = a;
        hRd = 1'b1;
        tick(1);
        hRd = 1'b0;
        chk("rdValid", 15'h1, regRdValid);
        chk("rdData", exp, regRdData);
        tick(1);
    endtask

    // bounded wait: a stuck load ends the run
    task automatic load;
        startLoad = 1'b1;
        tick(1);
        startLoad = 1'b0;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (ldBusy && n < 40);
        if (n >= 40) begin
            n_mismatch++;
            test_done();
        end
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end

    initial begin
        rows = '{'{8'h00, MN[0] - D, 13'h0, 1'b0}, '{8'h00, MN[0] + D, 13'h0, 1'b1},
                 '{8'h03, MN[3] - D, 13'h0, 1'b0}, '{8'h03, MN[3] + D, 13'h0, 1'b1},
                 '{8'h01, MN[1] - D, 13'h0, 1'b0}, '{8'h02, MN[2] - D, 13'h0, 1'b0},
                 '{8'h04, 13'h0, LW[0] - D, 1'b0}, '{8'h04, 13'h0, LW[0] + D, 1'b1},
                 '{8'h04, 13'h0, UP + D, 1'b0}, '{8'h05, 13'h0, LW[1] - D, 1'b0},
                 '{8'h06, 13'h0, LW[2] + D, 1'b1}, '{8'h07, 13'h0, LW[3] - D, 1'b0},
                 '{8'h07, 13'h0, UP - D, 1'b1}};
        repeat (5) @(posedge sys_clk);
        #2;
        chk("rstValid", 15'h0, regRdValid);
        chk("rstFlags", 15'h3, {amplitudeFaultFlagN, frequencyFaultFlagN});
        chk("rstOe", 15'h0, faultPinOe);
        tick(5);
        rst = 1'b0;
        load();
        chk("res", 15'h13, resolutionSelect);
        chk("gain", 15'h6, gainCode);
        chk("flim", 15'h4302, converterFrequencyLimit);
        chk("crcByte", 15'h3C, storedChecksumByte);
        for (int i = 0; i < 16; i++) rd(4'(i), i == 3 ? 8'h43 : IMG[8*i +: 8]);
        // host writes go to a full-width trim byte; unused bytes store any value written
        wr(icr_pkg::ADR_COS_TRIM, 8'hA5);
        rd(icr_pkg::ADR_COS_TRIM, 8'hA5);
        // amplitude monitor table; link held busy so the pin must stay released
        foreach (rows[r]) begin
            wr(icr_pkg::ADR_AMPLITUDE_THRESHOLD_CODE, rows[r].cfg);
            amplitudeMv = rows[r].amp;
            squareSumMv = rows[r].sq;
            tick(2);
            chk("ampFlag", rows[r].flagN, amplitudeFaultFlagN);
            chk("ampMode", rows[r].cfg[2:0], {amplitudeCheckSelect, amplitudeThresholdCode});
            chk("oeBusy", 15'h0, faultPinOe);
            rd(icr_pkg::ADR_LINK, {6'h10, rows[r].flagN, 1'b1});
        end
        // protection blocks host writes until the next load
        wr(icr_pkg::ADR_LINK, 8'h48);
        chk("prot", 15'h1, writeProtectLevel);
        wr(icr_pkg::ADR_FORMAT, 8'hFF);
        rd(icr_pkg::ADR_FORMAT, 8'h13);
        load();
        chk("protOff", 15'h0, writeProtectLevel);
        amplitudeMv = 13'h0FA0;
        squareSumMv = 13'h0BB8;
        accessBusy = 1'b0;
        tick(HOLD + 5);
        chk("oeIdle", 15'h0, faultPinOe);
        freqFault = 1'b1;
        tick(1);
        freqFault = 1'b0;
        chk("freqFlag", 15'h0, frequencyFaultFlagN);
        n = 0;
        for (int k = 0; k < HOLD + 10; k++) begin
            tick(1);
            if (faultPinOe === 1'b1) n++;
            if (k == HOLD / 2) chk("pinLevel", 15'h0, {faultPinLevel, faultPinOut});
        end
        chk("holdLen", 15'h1, n >= HOLD && n <= HOLD + 2);
        // a frame on the link withdraws the pin while the fault persists
        freqFault = 1'b1;
        serialClockIn = 1'b0;
        tick(4);
        chk("oeFrame", 15'h0, faultPinOe);
        serialClockIn = 1'b1;
        tick(4);
        chk("oeShow", 15'h1, faultPinOe);
        accessBusy = 1'b1;
        tick(2);
        chk("oeAccess", 15'h0, faultPinOe);
        freqFault = 1'b0;
        test_done();
    end
endmodule
